// *** hdl/tcm_consts.vh ***
// Register map, field positions, reset values and timing counts of the
// converter configuration block. Included by the block's design file only.
`ifndef TCM_CONSTS_VH
`define TCM_CONSTS_VH

// Byte addresses of the registers on the bus.
`define TCM_ADDR_CFG 4'h0
`define TCM_ADDR_CMD 4'h4
`define TCM_ADDR_STAT 4'h8
`define TCM_ADDR_RES 4'hC
`define TCM_ADDR_W 4

// Configuration register field positions.
`define TCM_CFG_DIV_LSB 0
`define TCM_CFG_START_LSB 2
`define TCM_CFG_XTAL_HI 5
`define TCM_CFG_NOISE 6
`define TCM_CFG_PHDIS 7
`define TCM_CFG_REINIT 8
`define TCM_CFG_ERRVAL 9
`define TCM_CFG_QUAD 10
`define TCM_CFG_DOUBLE 11
`define TCM_CFG_MODE2 12
`define TCM_CFG_W 13
`define TCM_CFG_RESET 13'h0000

// Start option codes.
`define TCM_ST_OFF 3'h0
`define TCM_ST_ON 3'h1
`define TCM_ST_480US 3'h2
`define TCM_ST_1460US 3'h3
`define TCM_ST_2440US 3'h4
`define TCM_ST_5140US 3'h5

// Command opcodes.
`define TCM_OP_INIT 8'h70
`define TCM_OP_POR 8'h50

// Settling times in whole microseconds and clock rate in kilohertz.
`define TCM_CLK_KHZ 10000
`define TCM_SETTLE_480_US 480
`define TCM_SETTLE_1460_US 1460
`define TCM_SETTLE_2440_US 2440
`define TCM_SETTLE_5140_US 5140
`define TCM_CYC(us) ((us) * `TCM_CLK_KHZ / 1000)

// All-ones error code written on timeout.
`define TCM_ERR_CODE 32'hFFFF_FFFF

`endif

// *** hdl/tcm_clock_mode_cfg.v ***
// Configuration and clock control of the time-to-digital converter core:
// predivider, fast oscillator start and settling, noise and resolution options,
// init and power-on-reset commands, timeout error code on results.
// Assumes an Avalon-MM master on mclk_i and a fast reference clock that is
// sampled here as a pin; the measurement core sits outside on the result ports.
`timescale 1ns/1ps
`include "tcm_consts.vh"

module tcm_clock_mode_cfg #(
  parameter S480 = `TCM_CYC(`TCM_SETTLE_480_US),
  parameter S1460 = `TCM_CYC(`TCM_SETTLE_1460_US),
  parameter S2440 = `TCM_CYC(`TCM_SETTLE_2440_US),
  parameter S5140 = `TCM_CYC(`TCM_SETTLE_5140_US)
) (
  input wire mclk_i,
  input wire rstn_i,
  input wire [3:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  output reg [31:0] avs_readdata_o,
  output reg avs_waitrequest_o,
  input wire fast_reference_clock_i,
  input wire meas_request_i,
  input wire irq_event_i,
  input wire result_valid_i,
  input wire [31:0] result_i,
  input wire timeout_i,
  output reg fast_osc_enable_o,
  output reg fast_clock_ready_o,
  output reg fast_clock_tick_o,
  output reg xtal_high_current_o,
  output reg start_noise_enable_o,
  output reg phase_noise_enable_o,
  output reg [1:0] resolution_factor_log2_o,
  output reg meas_init_o,
  output reg [31:0] result_o,
  output reg result_valid_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Local types.

  // Settle state machine codes.
  localparam ST_IDLE = 2'd0;
  localparam ST_SETTLE = 2'd1;
  localparam ST_RUN = 2'd2;

  // Settling count for a start option code; zero means no wait.
  // Codes 6 and 7 load zero and still enter the settle state, which they leave after one cycle.
  function [19:0] settle_cycles;
    input [2:0] code;
    begin
      case (code)
        `TCM_ST_480US: settle_cycles = S480[19:0];
        `TCM_ST_1460US: settle_cycles = S1460[19:0];
        `TCM_ST_2440US: settle_cycles = S2440[19:0];
        `TCM_ST_5140US: settle_cycles = S5140[19:0];
        default: settle_cycles = 20'h0_0000;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers.

  // All state sits on mclk_i; the fast reference is only ever sampled, never used as a clock.
  reg [`TCM_CFG_W-1:0] cfg_q; // Configuration word.
  reg [1:0] state_q; // Settle machine state.
  reg [19:0] settle_cnt_q; // Remaining settling cycles.
  reg [2:0] ref_sync_q; // Fast reference clock synchroniser.
  reg [1:0] div_cnt_q; // Predivider counter of reference edges.
  reg por_q; // Soft power-on-reset pending.
  reg mode2_bad_q; // Sticky: fourfold asked outside second mode.
  reg ref_level_q; // Last level on which synchroniser stages two and three agreed.

  wire [1:0] div_sel = cfg_q[`TCM_CFG_DIV_LSB +: 2];
  wire [2:0] start_sel = cfg_q[`TCM_CFG_START_LSB +: 3];
  wire bus_req = avs_read_i | avs_write_i;
  // Reference edge counts once the second and third stages agree high after an agreed low.
  // Demanding agreement filters a lone metastable sample at the price of one cycle of delay.
  wire ref_agree = ref_sync_q[1] == ref_sync_q[2];
  wire ref_edge = ref_agree && ref_sync_q[2] && !ref_level_q;
  wire cmd_init = avs_write_i && !avs_waitrequest_o && avs_address_i == `TCM_ADDR_CMD &&
                  avs_writedata_i[7:0] == `TCM_OP_INIT;
  wire cmd_por = avs_write_i && !avs_waitrequest_o && avs_address_i == `TCM_ADDR_CMD &&
                 avs_writedata_i[7:0] == `TCM_OP_POR;
  wire soft_rst = !rstn_i || por_q;

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: one wait cycle per access, then the answer.

  // Waitrequest is high while idle and drops for one cycle to complete a request.
  // A master that keeps its request past the low cycle is served a second time.
  always @(posedge mclk_i) begin
    if (!rstn_i) begin
      avs_waitrequest_o <= 1'b1;
    end else if (bus_req && avs_waitrequest_o) begin
      avs_waitrequest_o <= 1'b0;
    end else begin
      avs_waitrequest_o <= 1'b1;
    end
  end

  // Read data is prepared with the waitrequest drop; unmapped reads give zero.
  // Reads have no side effects, so a repeated read is harmless.
  always @(posedge mclk_i) begin
    if (!rstn_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (avs_read_i && avs_waitrequest_o) begin
      case (avs_address_i)
        `TCM_ADDR_CFG: avs_readdata_o <= {19'h0_0000, cfg_q};
        `TCM_ADDR_STAT: avs_readdata_o <= {27'h000_0000, mode2_bad_q, fast_clock_ready_o,
                                          fast_osc_enable_o, state_q};
        `TCM_ADDR_RES: avs_readdata_o <= result_o;
        default: avs_readdata_o <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration register and power-on-reset command.

  // The command register write of the reset opcode clears the configuration, clock and result registers a cycle later.
  // The bus slave itself is left alone, so the answer to the command is never lost.
  always @(posedge mclk_i) begin
    if (!rstn_i) begin
      por_q <= 1'b0;
    end else begin
      por_q <= cmd_por;
    end
  end

  // Configuration word; init leaves it alone, reset opcode clears it.
  // The delayed soft reset lets the accepting bus cycle finish before the word clears.
  always @(posedge mclk_i) begin
    if (soft_rst) begin
      cfg_q <= `TCM_CFG_RESET;
    end else if (avs_write_i && !avs_waitrequest_o && avs_address_i == `TCM_ADDR_CFG) begin
      cfg_q <= avs_writedata_i[`TCM_CFG_W-1:0];
    end
  end

  // Static option outputs follow the configuration word.
  // They lag the word by one cycle; the core must not expect same-cycle changes.
  always @(posedge mclk_i) begin
    if (soft_rst) begin
      xtal_high_current_o <= 1'b0;
      start_noise_enable_o <= 1'b0;
      // Phase noise starts enabled, the safer default for starts timed off the fast clock.
      phase_noise_enable_o <= 1'b1;
      resolution_factor_log2_o <= 2'd0;
      mode2_bad_q <= 1'b0;
    end else begin
      xtal_high_current_o <= cfg_q[`TCM_CFG_XTAL_HI];
      start_noise_enable_o <= cfg_q[`TCM_CFG_NOISE];
      phase_noise_enable_o <= ~cfg_q[`TCM_CFG_PHDIS];
      // Fourfold wins over twofold but only in the second measure mode.
      if (cfg_q[`TCM_CFG_QUAD] && cfg_q[`TCM_CFG_MODE2]) begin
        resolution_factor_log2_o <= 2'd2;
      end else if (cfg_q[`TCM_CFG_DOUBLE]) begin
        resolution_factor_log2_o <= 2'd1;
      end else begin
        resolution_factor_log2_o <= 2'd0;
      end
      if (cfg_q[`TCM_CFG_QUAD] && !cfg_q[`TCM_CFG_MODE2]) begin
        mode2_bad_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fast reference clock sampling and predivider.

  // Three-stage synchroniser; only stages two and three are examined.
  always @(posedge mclk_i) begin
    if (!rstn_i) begin
      ref_sync_q <= 3'b000;
    end else begin
      ref_sync_q <= {ref_sync_q[1:0], fast_reference_clock_i};
    end
  end

  // Agreed level of the reference pin; it starts low like a stopped oscillator,
  // so that no false edge follows reset.
  always @(posedge mclk_i) begin
    if (!rstn_i) begin
      ref_level_q <= 1'b0;
    end else if (ref_agree) begin
      ref_level_q <= ref_sync_q[2];
    end
  end

  // Tick every 1, 2 or 4 reference edges while the clock is ready.
  // The counter only advances on edges, so a divider change keeps the running phase.
  always @(posedge mclk_i) begin
    if (soft_rst) begin
      div_cnt_q <= 2'd0;
      fast_clock_tick_o <= 1'b0;
    end else if (ref_edge && fast_clock_ready_o) begin
      case (div_sel)
        2'd1: fast_clock_tick_o <= div_cnt_q[0];
        2'd2: fast_clock_tick_o <= &div_cnt_q;
        default: fast_clock_tick_o <= 1'b1;
      endcase
      div_cnt_q <= div_cnt_q + 2'd1;
    end else begin
      fast_clock_tick_o <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fast oscillator start and settling.

  // Off keeps it off, on keeps it running, other codes switch it on per request.
  // Ready drops together with the enable, so no tick leaves a stopped oscillator.
  always @(posedge mclk_i) begin
    if (soft_rst) begin
      state_q <= ST_IDLE;
      settle_cnt_q <= 20'h0_0000;
      fast_osc_enable_o <= 1'b0;
      fast_clock_ready_o <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          fast_clock_ready_o <= 1'b0;
          // Continuous mode skips settling: the oscillator has long been stable when used.
          if (start_sel == `TCM_ST_ON) begin
            fast_osc_enable_o <= 1'b1;
            fast_clock_ready_o <= 1'b1;
            state_q <= ST_RUN;
          end else if (start_sel != `TCM_ST_OFF && meas_request_i) begin
            fast_osc_enable_o <= 1'b1;
            settle_cnt_q <= settle_cycles(start_sel);
            state_q <= ST_SETTLE;
          end else begin
            fast_osc_enable_o <= 1'b0;
          end
        end
        ST_SETTLE: begin
          if (start_sel == `TCM_ST_OFF) begin
            fast_osc_enable_o <= 1'b0;
            state_q <= ST_IDLE;
          // Comparing with one makes ready rise after exactly the loaded number of cycles.
          end else if (settle_cnt_q <= 20'h0_0001) begin
            fast_clock_ready_o <= 1'b1;
            state_q <= ST_RUN;
          end else begin
            settle_cnt_q <= settle_cnt_q - 20'h0_0001;
          end
        end
        ST_RUN: begin
          // Continuous mode stays; per-measurement mode drops at interrupt.
          if (start_sel == `TCM_ST_OFF ||
              (start_sel != `TCM_ST_ON && (irq_event_i || cmd_init))) begin
            fast_osc_enable_o <= 1'b0;
            fast_clock_ready_o <= 1'b0;
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Init pulse and results.

  // Init comes from the opcode or, if enabled, from each interrupt.
  // Both in one cycle give a single pulse, never two.
  always @(posedge mclk_i) begin
    if (soft_rst) begin
      meas_init_o <= 1'b0;
    end else begin
      meas_init_o <= cmd_init || (irq_event_i && cfg_q[`TCM_CFG_REINIT]);
    end
  end

  // Results pass through; a timeout with error code enabled forces all ones.
  // The timeout flag is only looked at together with the result strobe.
  always @(posedge mclk_i) begin
    if (soft_rst) begin
      result_o <= 32'h0000_0000;
      result_valid_o <= 1'b0;
    end else begin
      result_valid_o <= result_valid_i;
      if (result_valid_i) begin
        result_o <= (timeout_i && cfg_q[`TCM_CFG_ERRVAL]) ? `TCM_ERR_CODE : result_i;
      end
    end
  end

endmodule // tcm_clock_mode_cfg

// *** test/tcm_cfg_monitor.sv ***
// Checker for the converter configuration block, bound to its top module.
// Assumes one bus master and cfg writes kept apart from result strobes.
`timescale 1ns/1ps
module tcm_cfg_monitor #(
  parameter S480 = 5,
  parameter S1460 = 10,
  parameter S2440 = 15,
  parameter S5140 = 20
) (
  input wire mclk_i,
  input wire rstn_i,
  input wire [3:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire avs_waitrequest_o,
  input wire irq_event_i,
  input wire result_valid_i,
  input wire [31:0] result_i,
  input wire timeout_i,
  input wire fast_osc_enable_o,
  input wire fast_clock_ready_o,
  input wire fast_clock_tick_o,
  input wire xtal_high_current_o,
  input wire start_noise_enable_o,
  input wire phase_noise_enable_o,
  input wire [1:0] resolution_factor_log2_o,
  input wire meas_init_o,
  input wire [31:0] result_o,
  input wire result_valid_o
);
  reg [12:0] cfg_q; // Shadow of the configuration word.
  reg [5:0] stb_q; // Cycles since the shadow changed; outputs may lag a few.
  reg [5:0] gap_q; // Cycles since the last divided tick.
  reg [7:0] on_q; // Cycles the oscillator has been on.
  wire acc = avs_write_i && !avs_waitrequest_o;
  wire por = acc && avs_address_i == 4'h4 && avs_writedata_i[7:0] == 8'h50;
  wire [2:0] st = cfg_q[4:2];
  wire [15:0] sv = st == 3'h2 ? S480 : st == 3'h3 ? S1460 : st == 3'h4 ? S2440 : S5140;
  wire [1:0] res = (cfg_q[10] && cfg_q[12]) ? 2'h2 : cfg_q[11] ? 2'h1 : 2'h0;
  ////////////////////////////////////////////////////////////////////////////
  // Helper counters; the reset opcode clears the shadow like a cfg write.
  always @(posedge mclk_i) begin
    if (!rstn_i) begin
      cfg_q <= 13'h0000;
      stb_q <= 6'h00;
    end else if (por || (acc && avs_address_i == 4'h0)) begin
      cfg_q <= por ? 13'h0000 : avs_writedata_i[12:0];
      stb_q <= 6'h00;
    end else begin
      stb_q <= stb_q + {5'h00, stb_q != 6'h3F};
    end
    gap_q <= fast_clock_tick_o ? 6'h00 : gap_q + 6'h01;
    on_q <= fast_osc_enable_o ? on_q + 8'h01 : 8'h00;
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  a_wait_answer: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("Bus access not answered after one cycle.");
  a_xtal_opt: assert property (stb_q > 6'h03 |-> xtal_high_current_o == cfg_q[5])
    else $error("Crystal current option differs from cfg.");
  a_noise_opt: assert property (stb_q > 6'h03 |-> start_noise_enable_o == cfg_q[6])
    else $error("Start noise enable differs from cfg.");
  a_phase_opt: assert property (stb_q > 6'h03 |-> phase_noise_enable_o == !cfg_q[7])
    else $error("Phase noise enable differs from cfg.");
  a_res_mode: assert property (stb_q > 6'h03 |-> resolution_factor_log2_o == res)
    else $error("Resolution factor wrong for cfg.");
  a_osc_level: assert property (stb_q > 6'h03 && st < 3'h2 |-> fast_osc_enable_o == st[0])
    else $error("Oscillator level wrong for start option.");
  a_err_code: assert property (result_valid_i && timeout_i && cfg_q[9] |=> result_valid_o && result_o == 32'hFFFF_FFFF)
    else $error("Timeout result is not all ones.");
  a_result_pass: assert property (result_valid_i && !(timeout_i && cfg_q[9]) |=> result_valid_o && result_o == $past(result_i))
    else $error("Result not passed through.");
  a_init_cmd: assert property (acc && avs_address_i == 4'h4 && avs_writedata_i[7:0] == 8'h70 |-> ##[1:2] meas_init_o)
    else $error("Init opcode gave no init pulse.");
  a_reinit_irq: assert property (irq_event_i && cfg_q[8] && stb_q > 6'h03 |-> ##[1:2] meas_init_o)
    else $error("Interrupt gave no automatic init.");
  a_div_ratio: assert property (fast_clock_tick_o && st == 3'h1 && stb_q > 6'h28 |-> gap_q == (6'h04 << cfg_q[1:0]) - 6'h01)
    else $error("Tick spacing wrong for predivider.");
  a_settle_time: assert property ($rose(fast_clock_ready_o) && st > 3'h1 |-> on_q + 8'h01 >= sv && on_q <= sv + 16'h0002)
    else $error("Settling time wrong for start option.");
  c_init: cover property (meas_init_o);
  c_ready: cover property ($rose(fast_clock_ready_o));
  c_err: cover property (result_valid_o && result_o == 32'hFFFF_FFFF);
endmodule // tcm_cfg_monitor

bind tcm_clock_mode_cfg tcm_cfg_monitor #(.S480(S480), .S1460(S1460), .S2440(S2440), .S5140(S5140)) i_mon (
  .mclk_i, .rstn_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_waitrequest_o,
  .irq_event_i, .result_valid_i, .result_i, .timeout_i, .fast_osc_enable_o, .fast_clock_ready_o,
  .fast_clock_tick_o, .xtal_high_current_o, .start_noise_enable_o, .phase_noise_enable_o,
  .resolution_factor_log2_o, .meas_init_o, .result_o, .result_valid_o);

// *** test/tcm_osc_model.sv ***
// Model of the fast reference oscillator feeding the block.
// Assumes it is stepped from mclk_i so its period is exactly four cycles.
`timescale 1ns/1ps
module tcm_osc_model (
  input wire mclk_i,
  input wire enable_i,
  output reg clk_o
);
  reg ph_q; // Half-period phase.
  initial begin
    clk_o = 1'b0;
    ph_q = 1'b0;
  end
  // Runs only while enabled and rests low when off, as a real part stops.
  always @(posedge mclk_i) begin
    ph_q <= enable_i ? !ph_q : 1'b0;
    if (!enable_i) clk_o <= 1'b0;
    else if (ph_q) clk_o <= !clk_o;
  end
endmodule // tcm_osc_model

// *** test/tb.sv ***
// Self-checking bench of the converter configuration block.
// Assumes short settling counts of 5, 10, 15 and 20 cycles.
`timescale 1ns/1ps
module tb;
  reg mclk_i, rstn_i, avs_read_i, avs_write_i, meas_request_i, irq_event_i, result_valid_i, timeout_i;
  reg [3:0] avs_address_i;
  reg [31:0] avs_writedata_i, result_i, v;
  wire [31:0] avs_readdata_o, result_o;
  wire avs_waitrequest_o, fast_osc_enable_o, fast_clock_ready_o, fast_clock_tick_o, xtal_high_current_o;
  wire start_noise_enable_o, phase_noise_enable_o, meas_init_o, result_valid_o, ref_clk;
  wire [1:0] resolution_factor_log2_o;
  integer errors, n_tests, i, n;
  tcm_clock_mode_cfg #(.S480(5), .S1460(10), .S2440(15), .S5140(20)) i_dut (.mclk_i(mclk_i), .rstn_i(rstn_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .fast_reference_clock_i(ref_clk), .meas_request_i(meas_request_i), .irq_event_i(irq_event_i),
    .result_valid_i(result_valid_i), .result_i(result_i), .timeout_i(timeout_i),
    .fast_osc_enable_o(fast_osc_enable_o), .fast_clock_ready_o(fast_clock_ready_o),
    .fast_clock_tick_o(fast_clock_tick_o), .xtal_high_current_o(xtal_high_current_o),
    .start_noise_enable_o(start_noise_enable_o), .phase_noise_enable_o(phase_noise_enable_o),
    .resolution_factor_log2_o(resolution_factor_log2_o), .meas_init_o(meas_init_o), .result_o(result_o),
    .result_valid_o(result_valid_o));
  tcm_osc_model i_osc (.mclk_i(mclk_i), .enable_i(fast_osc_enable_o), .clk_o(ref_clk));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk_i = 1'b0;
    forever #50 mclk_i = ~mclk_i;
  end
  task chk(input [31:0] s, input [31:0] e);
    begin
      n_tests = n_tests + 1;
      if (s !== e) begin
        errors = errors + 1;
        $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
      end
    end
  endtask
  task stop_test;
    begin
      $display("checks %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) begin
        $display("verification passed");
      end else begin
        $display("verification failed");
      end
      $finish;
    end
  endtask
  // Holds the request until waitrequest is sampled low; a hang is left to the watchdog.
  task wait_ack;
    begin
      @(posedge mclk_i);
      while (avs_waitrequest_o !== 1'b0) begin
        @(posedge mclk_i);
      end
    end
  endtask
  task wr(input [3:0] a, input [31:0] d);
    begin
      @(posedge mclk_i);
      avs_address_i <= a;
      avs_writedata_i <= d;
      avs_write_i <= 1'b1;
      wait_ack;
      avs_write_i <= 1'b0;
    end
  endtask
  task rd(input [3:0] a);
    begin
      @(posedge mclk_i);
      avs_address_i <= a;
      avs_read_i <= 1'b1;
      wait_ack;
      v = avs_readdata_o;
      avs_read_i <= 1'b0;
    end
  endtask
  task see_init;
    integer k;
    begin
      k = 0;
      while (meas_init_o !== 1'b1 && k < 6) begin
        @(posedge mclk_i);
        k = k + 1;
      end
      chk({31'h0, k < 6}, 32'h0000_0001);
    end
  endtask
  task irq;
    begin
      @(posedge mclk_i);
      irq_event_i <= 1'b1;
      @(posedge mclk_i);
      irq_event_i <= 1'b0;
    end
  endtask
  task res(input [31:0] d, input t, input [31:0] e);
    begin
      @(posedge mclk_i);
      result_valid_i <= 1'b1;
      result_i <= d;
      timeout_i <= t;
      @(posedge mclk_i);
      result_valid_i <= 1'b0;
      @(posedge mclk_i);
      chk(result_o, e);
      chk(result_valid_o, 32'h0000_0001);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Watchdog reckoned at roughly forty times the expected run length.
  initial begin
    repeat (20000) @(posedge mclk_i);
    errors = errors + 1;
    stop_test;
  end
  initial begin
    {rstn_i, avs_read_i, avs_write_i, meas_request_i, irq_event_i, result_valid_i, timeout_i} = 7'h00;
    avs_address_i = 4'h0;
    avs_writedata_i = 32'h0000_0000;
    result_i = 32'h0000_0000;
    errors = 0;
    n_tests = 0;
    repeat (6) @(posedge mclk_i);
    rstn_i <= 1'b1;
    rd(4'h0);
    chk(v, 32'h0000_0000);
    chk(phase_noise_enable_o, 32'h0000_0001);
    rd(4'h2);
    chk(v, 32'h0000_0000);
    $display("end reset test");
    wr(4'h0, 32'h0000_01E0);
    rd(4'h0);
    repeat (3) @(posedge mclk_i);
    chk(xtal_high_current_o, 32'h0000_0001);
    chk(start_noise_enable_o, 32'h0000_0001);
    chk(phase_noise_enable_o, 32'h0000_0000);
    wr(4'h4, 32'h0000_0070);
    see_init;
    rd(4'h0);
    chk(v, 32'h0000_01E0);
    irq;
    see_init;
    $display("end option test");
    for (i = 0; i < 8; i = i + 1) begin
      wr(4'h0, i << 10);
      repeat (3) @(posedge mclk_i);
      chk(resolution_factor_log2_o, (i[0] && i[2]) ? 2 : i[1]);
    end
    rd(4'h8);
    chk(v, 32'h0000_0010);
    // Tick spacing is judged by the checker; the bench counts ticks in a settled 64-cycle window.
    for (i = 0; i < 3; i = i + 1) begin
      wr(4'h0, i | 4);
      repeat (32) @(posedge mclk_i);
      n = 0;
      repeat (64) begin
        @(posedge mclk_i);
        n = n + fast_clock_tick_o;
      end
      chk(n, 16 >> i);
      chk(fast_osc_enable_o, 32'h0000_0001);
      rd(4'h8);
      chk(v, 32'h0000_001E);
    end
    wr(4'h0, 32'h0000_0000);
    repeat (3) @(posedge mclk_i);
    chk(fast_osc_enable_o, 32'h0000_0000);
    for (i = 2; i < 6; i = i + 1) begin
      wr(4'h0, i << 2);
      @(posedge mclk_i);
      meas_request_i <= 1'b1;
      n = 0;
      while (fast_clock_ready_o !== 1'b1 && n < 100) begin
        @(posedge mclk_i);
        n = n + 1;
      end
      chk({31'h0, n >= 5 * i - 5 && n <= 5 * i}, 32'h0000_0001);
      meas_request_i <= 1'b0;
      irq;
      repeat (3) @(posedge mclk_i);
      chk(fast_osc_enable_o, 32'h0000_0000);
    end
    $display("end clock test");
    wr(4'h0, 32'h0000_0200);
    res(32'h1234_5678, 1'b1, 32'hFFFF_FFFF);
    res(32'h1234_5678, 1'b0, 32'h1234_5678);
    wr(4'h0, 32'h0000_0000);
    res(32'hCAFE_0001, 1'b1, 32'hCAFE_0001);
    rd(4'hC);
    chk(v, 32'hCAFE_0001);
    wr(4'h0, 32'h0000_01E0);
    wr(4'h4, 32'h0000_0050);
    repeat (3) @(posedge mclk_i);
    rd(4'h0);
    chk(v, 32'h0000_0000);
    chk(phase_noise_enable_o, 32'h0000_0001);
    rd(4'h8);
    chk(v, 32'h0000_0000);
    $display("end result and reset test");
    stop_test;
  end
endmodule // tb
